//--- icsd_top.sv
// icsd_top: two programmable chip-select decoders watching ISA cycles, with
// the board sub-decode for two fieldbus controllers and two isolated uarts,
// and the board interrupt wiring toward the expansion connector.
// Assumes: ISA strobes and addresses arrive asynchronously from pins; the
// configuration port strobes are one-cycle pulses on clk_sys_i.
//
// Notes on behaviour
// - base bit 0 turns a decoder on; while clear its select never asserts.
// - mask bit 27 lets read cycles hit; clear means reads never hit.
// - mask bit 26 lets write cycles hit; clear means writes never hit.
// - mask bit 25 picks 8-bit cycles when 0, 16-bit cycles when 1.
// - mask bit 24 picks io cycles when 0, memory cycles when 1.
// - mask bits 23-1 cover address 31-9 in memory, 15-1 in io.
// - base bits 31-1 hold the origin; io compares only bits 15-1.
// - each fieldbus controller gets 256 register bytes then 256 reset bytes.
// - any 8-bit read or write in a reset area resets that controller.
// - first controller's two areas come first, the second's right after.
// - fieldbus window defaults to 0xDF000, blocks at DF000 through DF300.
// - first fieldbus interrupt drives line 10, second drives line 11.
// - two uarts decode as consecutive 8-byte io blocks, first below second.
// - serial window defaults to io 220; ports at 220-227 and 228-22F.
// - first uart interrupt drives line 7, second drives line 9.
// - request lines 3-7, 9-12, 14-15 go straight to the connector.
// - nmi sources signal through the channel-check line, not a request.
// - registers at bus 0 dev 7 fn 0, offsets 90h, 94h, 98h, 9Ch.
`default_nettype none

module icsd_top
	import icsd_pkg::*;
(
	input  wire logic        clk_sys_i,               // system clock, 250 MHz
	input  wire logic        resetn_i,                // async reset, active low
	// configuration port (same clock)
	input  wire logic [15:0] cfg_io_addr_i,           // io port address
	input  wire logic        cfg_io_wr_i,             // write pulse
	input  wire logic        cfg_io_rd_i,             // read pulse
	input  wire logic [31:0] cfg_io_wdata_i,          // write data
	output logic      [31:0] cfg_io_rdata_o,          // read data
	output logic             cfg_io_rvalid_o,         // read data valid pulse
	// ISA cycle pins (asynchronous)
	input  wire logic [31:0] isa_addr_i,              // cycle address
	input  wire logic        isa_ior_n_i,             // io read, low
	input  wire logic        isa_iow_n_i,             // io write, low
	input  wire logic        isa_memr_n_i,            // memory read, low
	input  wire logic        isa_memw_n_i,            // memory write, low
	input  wire logic        isa_wide_i,              // 16-bit cycle, high
	// selects
	output logic             chip_select_zero_n_o,    // decoder 0 select, low
	output logic             chip_select_one_n_o,     // decoder 1 select, low
	output logic             first_fieldbus_sel_n_o,  // first controller regs, low
	output logic             first_fieldbus_rst_n_o,  // first controller reset, low
	output logic             second_fieldbus_sel_n_o, // second controller regs, low
	output logic             second_fieldbus_rst_n_o, // second controller reset, low
	output logic             first_uart_sel_n_o,      // first uart select, low
	output logic             second_uart_sel_n_o,     // second uart select, low
	// interrupts (asynchronous in)
	input  wire logic        first_fieldbus_irq_i,    // first controller irq, high
	input  wire logic        second_fieldbus_irq_i,   // second controller irq, high
	input  wire logic        first_uart_irq_i,        // first uart irq, high
	input  wire logic        second_uart_irq_i,       // second uart irq, high
	input  wire logic [15:0] soc_irq_i,               // other request sources
	input  wire logic        nmi_src_i,               // nmi source, high
	output logic      [15:0] expansion_irq_o,         // request lines to connector
	output logic             isa_chk_n_o              // channel check, low
);
	localparam int SYNC_W = 58;
	// strobes park high in reset so the first edges after release see an idle bus
	localparam logic [SYNC_W-1:0] SYNC_IDLE = {32'h00000000, 4'hF, 22'h000000};

	// two-flop synchroniser for every pin input
	logic [SYNC_W-1:0] sync_meta;
	logic [SYNC_W-1:0] sync_out;
	logic [SYNC_W-1:0] pin_bus;

	assign pin_bus = {isa_addr_i, isa_ior_n_i, isa_iow_n_i, isa_memr_n_i, isa_memw_n_i,
	                  isa_wide_i, first_fieldbus_irq_i, second_fieldbus_irq_i,
	                  first_uart_irq_i, second_uart_irq_i, soc_irq_i, nmi_src_i};

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync_meta <= SYNC_IDLE;
			sync_out  <= SYNC_IDLE;
		end else begin
			sync_meta <= pin_bus;
			sync_out  <= sync_meta;
		end
	end

	logic [31:0] s_addr;
	logic        s_ior_n;
	logic        s_iow_n;
	logic        s_memr_n;
	logic        s_memw_n;
	logic        s_wide;
	logic        s_fb1_irq;
	logic        s_fb2_irq;
	logic        s_uart1_irq;
	logic        s_uart2_irq;
	logic [15:0] s_soc_irq;
	logic        s_nmi;

	assign {s_addr, s_ior_n, s_iow_n, s_memr_n, s_memw_n, s_wide, s_fb1_irq, s_fb2_irq,
	        s_uart1_irq, s_uart2_irq, s_soc_irq, s_nmi} = sync_out;

	// configuration address latch and data window
	logic [31:0] cfg_addr;
	logic [31:0] base_reg [NUM_DECODERS];
	logic [31:0] mask_reg [NUM_DECODERS];

	logic        at_addr_port;
	logic        at_data_port;
	logic        func_match;
	logic        sel_zero_base;
	logic        sel_zero_mask;
	logic        sel_one_base;
	logic        sel_one_mask;
	logic        data_wr;
	logic [31:0] func_rdata;
	logic [31:0] next_rdata;

	assign at_addr_port  = (cfg_io_addr_i == CFG_ADDR_PORT);
	assign at_data_port  = (cfg_io_addr_i == CFG_DATA_PORT);
	assign func_match    = cfg_addr[CFG_EN_BIT]
	                     & (cfg_addr[23:16] == CFG_BUS)
	                     & (cfg_addr[15:11] == CFG_DEV)
	                     & (cfg_addr[10:8] == CFG_FUNC);
	assign sel_zero_base = func_match & (cfg_addr[7:0] == REG_ZERO_BASE);
	assign sel_zero_mask = func_match & (cfg_addr[7:0] == REG_ZERO_MASK);
	assign sel_one_base  = func_match & (cfg_addr[7:0] == REG_ONE_BASE);
	assign sel_one_mask  = func_match & (cfg_addr[7:0] == REG_ONE_MASK);
	assign data_wr       = cfg_io_wr_i & at_data_port;

	// a function that does not match reads all ones, like an empty slot
	assign func_rdata = sel_zero_base ? base_reg[0] :
	                    sel_zero_mask ? mask_reg[0] :
	                    sel_one_base  ? base_reg[1] :
	                    sel_one_mask  ? mask_reg[1] :
	                    func_match    ? 32'h00000000 : CFG_NO_DEVICE;
	assign next_rdata = at_addr_port ? cfg_addr :
	                    at_data_port ? func_rdata : 32'h00000000;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg_addr <= 32'h00000000;
		end else if (cfg_io_wr_i && at_addr_port) begin
			cfg_addr <= cfg_io_wdata_i & CFG_ADDR_WMASK;
		end
	end

	// one write port per decoder; mask writes drop the reserved bits
	localparam logic [31:0] RST_BASE [NUM_DECODERS] = '{RST_ZERO_BASE, RST_ONE_BASE};
	localparam logic [31:0] RST_MASK [NUM_DECODERS] = '{RST_ZERO_MASK, RST_ONE_MASK};

	logic [NUM_DECODERS-1:0] wr_base;
	logic [NUM_DECODERS-1:0] wr_mask;

	assign wr_base = {data_wr & sel_one_base, data_wr & sel_zero_base};
	assign wr_mask = {data_wr & sel_one_mask, data_wr & sel_zero_mask};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_DECODERS; gi++) begin : g_regs
			logic [31:0] base_q;
			logic [31:0] mask_q;

			always_ff @(posedge clk_sys_i or negedge resetn_i) begin
				if (!resetn_i) begin
					base_q <= RST_BASE[gi];
					mask_q <= RST_MASK[gi];
				end else begin
					if (wr_base[gi]) begin
						base_q <= cfg_io_wdata_i;
					end
					if (wr_mask[gi]) begin
						mask_q <= cfg_io_wdata_i & MASK_WMASK;
					end
				end
			end

			assign base_reg[gi] = base_q;
			assign mask_reg[gi] = mask_q;
		end
	endgenerate

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg_io_rdata_o  <= 32'h00000000;
			cfg_io_rvalid_o <= 1'b0;
		end else begin
			cfg_io_rdata_o  <= cfg_io_rd_i ? next_rdata : 32'h00000000;
			cfg_io_rvalid_o <= cfg_io_rd_i;
		end
	end

	// window comparators, one per decoder
	logic [NUM_DECODERS-1:0] hit;

	generate
		for (gi = 0; gi < NUM_DECODERS; gi++) begin : g_dec
			icsd_window_match u_match (
				.base_i   (base_reg[gi]),
				.mask_i   (mask_reg[gi]),
				.addr_i   (s_addr),
				.io_rd_i  (~s_ior_n),
				.io_wr_i  (~s_iow_n),
				.mem_rd_i (~s_memr_n),
				.mem_wr_i (~s_memw_n),
				.wide_i   (s_wide),
				.hit_o    (hit[gi])
			);
		end
	endgenerate

	// board sub-decode of the two windows
	// raw address bits pick the area, so each window must sit on its own size
	logic [1:0] fb_area;
	logic       next_fb1_sel;
	logic       next_fb1_rst;
	logic       next_fb2_sel;
	logic       next_fb2_rst;
	logic       next_uart1_sel;
	logic       next_uart2_sel;

	assign fb_area        = s_addr[FB_AREA_HI:FB_AREA_LO];
	assign next_fb1_sel   = hit[0] & (fb_area == FB_FIRST_REGS);
	assign next_fb1_rst   = hit[0] & (fb_area == FB_FIRST_RST);
	assign next_fb2_sel   = hit[0] & (fb_area == FB_SECOND_REGS);
	assign next_fb2_rst   = hit[0] & (fb_area == FB_SECOND_RST);
	assign next_uart1_sel = hit[1] & ~s_addr[UART_PORT_BIT];
	assign next_uart2_sel = hit[1] &  s_addr[UART_PORT_BIT];

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			chip_select_zero_n_o    <= 1'b1;
			chip_select_one_n_o     <= 1'b1;
		end else begin
			chip_select_zero_n_o    <= ~hit[0];
			chip_select_one_n_o     <= ~hit[1];
		end
	end

	// a reset-area select is a level that lasts as long as the access does
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			first_fieldbus_sel_n_o  <= 1'b1;
			first_fieldbus_rst_n_o  <= 1'b1;
			second_fieldbus_sel_n_o <= 1'b1;
			second_fieldbus_rst_n_o <= 1'b1;
			first_uart_sel_n_o      <= 1'b1;
			second_uart_sel_n_o     <= 1'b1;
		end else begin
			first_fieldbus_sel_n_o  <= ~next_fb1_sel;
			first_fieldbus_rst_n_o  <= ~next_fb1_rst;
			second_fieldbus_sel_n_o <= ~next_fb2_sel;
			second_fieldbus_rst_n_o <= ~next_fb2_rst;
			first_uart_sel_n_o      <= ~next_uart1_sel;
			second_uart_sel_n_o     <= ~next_uart2_sel;
		end
	end

	// interrupt wiring: board sources merge into fixed lines
	logic [15:0] board_irq;
	logic [15:0] next_irq;

	generate
		for (gi = 0; gi < 16; gi++) begin : g_irq
			if (gi == IRQ_FIRST_FB) begin : g_fb1
				assign board_irq[gi] = s_fb1_irq;
			end else if (gi == IRQ_SECOND_FB) begin : g_fb2
				assign board_irq[gi] = s_fb2_irq;
			end else if (gi == IRQ_FIRST_UART) begin : g_u1
				assign board_irq[gi] = s_uart1_irq;
			end else if (gi == IRQ_SECOND_UART) begin : g_u2
				assign board_irq[gi] = s_uart2_irq;
			end else begin : g_none
				assign board_irq[gi] = 1'b0;
			end
		end
	endgenerate

	assign next_irq = (board_irq | s_soc_irq) & CONNECTOR_IRQS;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			expansion_irq_o <= 16'h0000;
		end else begin
			expansion_irq_o <= next_irq;
		end
	end

	// nmi sources never take a numbered line; they only pull channel check low
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			isa_chk_n_o <= 1'b1;
		end else begin
			isa_chk_n_o <= ~s_nmi;
		end
	end
endmodule : icsd_top

`default_nettype wire

//--- icsd_window_match.sv
// icsd_pkg: constants shared by the chip-select decoder block.
// icsd_window_match: one window comparator; purely combinational, and the
// caller registers its output and feeds it already synchronised cycle strobes.
`default_nettype none

package icsd_pkg;
	// configuration port addresses and the function that owns the decoders
	localparam logic [15:0] CFG_ADDR_PORT   = 16'h0CF8;
	localparam logic [15:0] CFG_DATA_PORT   = 16'h0CFC;
	localparam logic [7:0]  CFG_BUS         = 8'h00;
	localparam logic [4:0]  CFG_DEV         = 5'h07;
	localparam logic [2:0]  CFG_FUNC        = 3'h0;
	localparam int          CFG_EN_BIT      = 31;
	localparam logic [31:0] CFG_ADDR_WMASK  = 32'h80FFFFFC;
	localparam logic [31:0] CFG_NO_DEVICE   = 32'hFFFFFFFF;
	// register offsets in configuration space
	localparam logic [7:0]  REG_ZERO_BASE   = 8'h90;
	localparam logic [7:0]  REG_ZERO_MASK   = 8'h94;
	localparam logic [7:0]  REG_ONE_BASE    = 8'h98;
	localparam logic [7:0]  REG_ONE_MASK    = 8'h9C;
	// reset values: fieldbus window at 0xDF000, serial window at 0x220
	localparam logic [31:0] RST_ZERO_BASE   = 32'h000DF001;
	localparam logic [31:0] RST_ZERO_MASK   = 32'h0DFFFFFC;
	localparam logic [31:0] RST_ONE_BASE    = 32'h00000221;
	localparam logic [31:0] RST_ONE_MASK    = 32'h0C00FFF0;
	// field positions
	localparam int          BASE_ON_BIT     = 0;
	localparam int          MASK_RD_BIT     = 27;
	localparam int          MASK_WR_BIT     = 26;
	localparam int          MASK_WIDE_BIT   = 25;
	localparam int          MASK_SPACE_BIT  = 24;
	localparam logic [31:0] MASK_WMASK      = 32'h0FFFFFFE;
	// sub-decode inside the windows
	localparam int          FB_AREA_HI      = 9;
	localparam int          FB_AREA_LO      = 8;
	localparam logic [1:0]  FB_FIRST_REGS   = 2'h0;
	localparam logic [1:0]  FB_FIRST_RST    = 2'h1;
	localparam logic [1:0]  FB_SECOND_REGS  = 2'h2;
	localparam logic [1:0]  FB_SECOND_RST   = 2'h3;
	localparam int          UART_PORT_BIT   = 3;
	// interrupt line numbers and the lines that reach the connector
	localparam int          IRQ_FIRST_FB    = 10;
	localparam int          IRQ_SECOND_FB   = 11;
	localparam int          IRQ_FIRST_UART  = 7;
	localparam int          IRQ_SECOND_UART = 9;
	localparam logic [15:0] CONNECTOR_IRQS  = 16'hDEF8;
	localparam int          NUM_DECODERS    = 2;
endpackage : icsd_pkg

module icsd_window_match
	import icsd_pkg::*;
(
	input  wire logic [31:0] base_i,      // base register
	input  wire logic [31:0] mask_i,      // mask register
	input  wire logic [31:0] addr_i,      // cycle address
	input  wire logic        io_rd_i,     // io read active
	input  wire logic        io_wr_i,     // io write active
	input  wire logic        mem_rd_i,    // memory read active
	input  wire logic        mem_wr_i,    // memory write active
	input  wire logic        wide_i,      // 16-bit cycle
	output logic             hit_o        // window hit
);
	logic        space_mem;
	logic        rd_cyc;
	logic        wr_cyc;
	logic        dir_ok;
	logic        width_ok;
	logic [31:0] cmp_bits;
	logic        addr_ok;

	assign space_mem = mask_i[MASK_SPACE_BIT];
	assign rd_cyc    = space_mem ? mem_rd_i : io_rd_i;
	assign wr_cyc    = space_mem ? mem_wr_i : io_wr_i;
	assign dir_ok    = (rd_cyc & mask_i[MASK_RD_BIT])
	                 | (wr_cyc & mask_i[MASK_WR_BIT]);
	assign width_ok  = (wide_i == mask_i[MASK_WIDE_BIT]);
	// set mask bits are compared; memory maps field to 31..9, io to 15..1
	assign cmp_bits  = space_mem ? {mask_i[23:1], 9'h000}
	                             : {16'h0000, mask_i[15:1], 1'b0};
	assign addr_ok   = (((addr_i ^ base_i) & cmp_bits) == 32'h00000000);
	assign hit_o     = base_i[BASE_ON_BIT] & dir_ok & width_ok & addr_ok;
endmodule : icsd_window_match

`default_nettype wire

//--- icsd_top_properties.sv
// icsd_top_checker: port-level assertions for the chip-select decoder.
// Assumes binding to icsd_top; selects and irq lines lag their pins by three edges.
`default_nettype none

module icsd_top_checker
	import icsd_pkg::*;
(
	input wire logic        clk_sys_i,               // clock
	input wire logic        resetn_i,                // reset, low
	input wire logic        cfg_io_rd_i,             // read pulse
	input wire logic [31:0] cfg_io_rdata_o,          // read data
	input wire logic        cfg_io_rvalid_o,         // read valid
	input wire logic [31:0] isa_addr_i,              // cycle address
	input wire logic        isa_ior_n_i,             // io read
	input wire logic        isa_iow_n_i,             // io write
	input wire logic        isa_memr_n_i,            // mem read
	input wire logic        isa_memw_n_i,            // mem write
	input wire logic        chip_select_zero_n_o,    // decoder 0
	input wire logic        chip_select_one_n_o,     // decoder 1
	input wire logic        first_fieldbus_sel_n_o,  // fb1 regs
	input wire logic        first_fieldbus_rst_n_o,  // fb1 reset
	input wire logic        second_fieldbus_sel_n_o, // fb2 regs
	input wire logic        second_fieldbus_rst_n_o, // fb2 reset
	input wire logic        first_uart_sel_n_o,      // uart1
	input wire logic        second_uart_sel_n_o,     // uart2
	input wire logic        first_fieldbus_irq_i,    // fb1 irq
	input wire logic        second_fieldbus_irq_i,   // fb2 irq
	input wire logic        first_uart_irq_i,        // uart1 irq
	input wire logic        second_uart_irq_i,       // uart2 irq
	input wire logic [15:0] soc_irq_i,               // other sources
	input wire logic        nmi_src_i,               // nmi source
	input wire logic [15:0] expansion_irq_o,         // connector lines
	input wire logic        isa_chk_n_o              // channel check
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] board_irq;
	logic        any_cycle;
	assign board_irq = soc_irq_i | {4'h0, second_fieldbus_irq_i, first_fieldbus_irq_i,
		second_uart_irq_i, 1'b0, first_uart_irq_i, 7'h0};
	assign any_cycle = !(isa_ior_n_i && isa_iow_n_i && isa_memr_n_i && isa_memw_n_i);

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	a_rvalid_follow: assert property (cfg_io_rvalid_o == $past(cfg_io_rd_i))
		else $error("read valid does not follow the read strobe");
	a_rdata_idle: assert property (!cfg_io_rvalid_o |-> cfg_io_rdata_o == 32'h0)
		else $error("read data not zero outside a read");
	a_fb_regs_one: assert property (!first_fieldbus_sel_n_o |-> !chip_select_zero_n_o
		&& $past(isa_addr_i[9:8], 3) == 2'h0) else $error("first fieldbus regs misdecoded");
	a_fb_rst_one: assert property (!first_fieldbus_rst_n_o |-> !chip_select_zero_n_o
		&& $past(isa_addr_i[9:8], 3) == 2'h1) else $error("first fieldbus reset misdecoded");
	a_fb_regs_two: assert property (!second_fieldbus_sel_n_o |-> !chip_select_zero_n_o
		&& $past(isa_addr_i[9:8], 3) == 2'h2) else $error("second fieldbus regs misdecoded");
	a_fb_rst_two: assert property (!second_fieldbus_rst_n_o |-> !chip_select_zero_n_o
		&& $past(isa_addr_i[9:8], 3) == 2'h3) else $error("second fieldbus reset misdecoded");
	a_uart_split: assert property (!chip_select_one_n_o |->
		first_uart_sel_n_o == $past(isa_addr_i[3], 3) && second_uart_sel_n_o != first_uart_sel_n_o)
		else $error("uart port split wrong");
	a_irq_route: assert property (expansion_irq_o == ($past(board_irq, 3) & 16'hDEF8))
		else $error("connector irq lines wrong");
	a_nmi_check: assert property (isa_chk_n_o == !$past(nmi_src_i, 3))
		else $error("channel check does not follow nmi source");
	a_sel_cycle: assert property ((!chip_select_zero_n_o || !chip_select_one_n_o)
		|-> $past(any_cycle, 3)) else $error("select without a bus cycle");

	c_fb_reset: cover property (!first_fieldbus_rst_n_o);
	c_uart_two: cover property (!second_uart_sel_n_o);
	c_cfg_read: cover property (cfg_io_rvalid_o);
endmodule : icsd_top_checker

`default_nettype wire

//--- icsd_isa_periph.sv
// icsd_isa_periph: stand-in for the fieldbus controllers and uarts on the bus.
// Assumes active-low reset selects from the decoder; irqs raised on bench request.
`default_nettype none

module icsd_isa_periph (
	input  wire logic        clk_sys_i,  // clock
	input  wire logic        resetn_i,   // reset, low
	input  wire logic [1:0]  fb_rst_n_i, // {second, first} reset selects
	input  wire logic [3:0]  irq_req_i,  // bench irq request
	output logic      [3:0]  irq_o,      // {uart2, uart1, fb2, fb1}
	output logic      [15:0] rst_cnt_o   // {second, first} reset counts
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] last_n;
	assign irq_o = irq_req_i;
	// any access to a reset area resets the controller, counted per entry
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			last_n    <= 2'h3;
			rst_cnt_o <= 16'h0;
		end else begin
			last_n <= fb_rst_n_i;
			if (last_n[0] && !fb_rst_n_i[0]) rst_cnt_o[7:0] <= rst_cnt_o[7:0] + 8'h01;
			if (last_n[1] && !fb_rst_n_i[1]) rst_cnt_o[15:8] <= rst_cnt_o[15:8] + 8'h01;
		end
	end
endmodule : icsd_isa_periph

`default_nettype wire

//--- isa_chip_select_decoder_test.sv
// isa_chip_select_decoder_test: self-checking bench for icsd_top.
// Assumes the package icsd_pkg, the peripheral model and the checker are compiled first.
`default_nettype none

module isa_chip_select_decoder_test;
	timeunit 1ns;
	timeprecision 1ps;
	import icsd_pkg::*;
	localparam int IOR = 0, IOW = 1, MRD = 2, MWR = 3;
	logic        clk_sys_i, resetn_i, cfg_io_wr_i, cfg_io_rd_i, cfg_io_rvalid_o, nmi_src_i;
	logic [15:0] cfg_io_addr_i, soc_irq_i, expansion_irq_o, rst_cnt;
	logic [31:0] cfg_io_wdata_i, cfg_io_rdata_o, isa_addr_i;
	logic        isa_ior_n_i, isa_iow_n_i, isa_memr_n_i, isa_memw_n_i, isa_wide_i, isa_chk_n_o;
	logic        chip_select_zero_n_o, chip_select_one_n_o, first_uart_sel_n_o;
	logic        first_fieldbus_sel_n_o, first_fieldbus_rst_n_o, second_uart_sel_n_o;
	logic        second_fieldbus_sel_n_o, second_fieldbus_rst_n_o;
	wire logic   first_fieldbus_irq_i, second_fieldbus_irq_i, first_uart_irq_i, second_uart_irq_i;
	logic [3:0]  irq_req;
	wire  [7:0]  sel = ~{chip_select_zero_n_o, chip_select_one_n_o, first_fieldbus_sel_n_o,
		first_fieldbus_rst_n_o, second_fieldbus_sel_n_o, second_fieldbus_rst_n_o,
		first_uart_sel_n_o, second_uart_sel_n_o};
	int          err_total, n_tests, cyc;

	icsd_top icsd_top_inst (.*);
	icsd_isa_periph icsd_isa_periph_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.fb_rst_n_i({second_fieldbus_rst_n_o, first_fieldbus_rst_n_o}), .irq_req_i(irq_req),
		.irq_o({second_uart_irq_i, first_uart_irq_i, second_fieldbus_irq_i, first_fieldbus_irq_i}),
		.rst_cnt_o(rst_cnt));

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude

	task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk_word

	task automatic chk_sel(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk_sel

	task automatic cfg_wr(input logic [15:0] port, input logic [31:0] d);
		@(negedge clk_sys_i);
		cfg_io_addr_i = port;
		cfg_io_wdata_i = d;
		cfg_io_wr_i = 1'b1;
		@(negedge clk_sys_i);
		cfg_io_wr_i = 1'b0;
	endtask : cfg_wr

	task automatic reg_wr(input logic [7:0] off, input logic [31:0] d);
		cfg_wr(16'h0CF8, {24'h800038, off});
		cfg_wr(16'h0CFC, d);
	endtask : reg_wr

	task automatic cfg_rd(input logic [31:0] ca, input logic [31:0] exp);
		cfg_wr(16'h0CF8, ca);
		cfg_io_addr_i = 16'h0CFC;
		cfg_io_rd_i = 1'b1;
		@(negedge clk_sys_i);
		cfg_io_rd_i = 1'b0;
		chk_word("read valid", 32'h1, {31'h0, cfg_io_rvalid_o});
		chk_word("config read", exp, cfg_io_rdata_o);
	endtask : cfg_rd

	task automatic isa(input int kind, input logic [31:0] a, input logic w, input logic [7:0] exp);
		@(negedge clk_sys_i);
		isa_addr_i = a;
		isa_wide_i = w;
		{isa_ior_n_i, isa_iow_n_i, isa_memr_n_i, isa_memw_n_i} = ~(4'h8 >> kind);
		repeat (4) @(negedge clk_sys_i);
		chk_sel("selects", exp, sel);
		{isa_ior_n_i, isa_iow_n_i, isa_memr_n_i, isa_memw_n_i} = 4'hF;
		repeat (4) @(negedge clk_sys_i);
		chk_sel("selects idle", 8'h00, sel);
	endtask : isa

	task automatic t_regs;
		cfg_rd(32'h80003890, 32'h000DF001);
		cfg_rd(32'h80003894, 32'h0DFFFFFC);
		cfg_rd(32'h80003898, 32'h00000221);
		cfg_rd(32'h8000389C, 32'h0C00FFF0);
		cfg_rd(32'h800038A0, 32'h00000000);
		cfg_rd(32'h80004090, 32'hFFFFFFFF);
		reg_wr(8'h94, 32'hFFFFFFFF);
		cfg_rd(32'h80003894, 32'h0FFFFFFE);
		reg_wr(8'h94, 32'h0DFFFFFC);
		$display("test regs done");
	endtask : t_regs

	task automatic t_fieldbus;
		isa(MRD, 32'h000DF000, 1'b0, 8'hA0);
		isa(MRD, 32'h000DF100, 1'b0, 8'h90);
		isa(MWR, 32'h000DF100, 1'b0, 8'h90);
		isa(MRD, 32'h000DF200, 1'b0, 8'h88);
		isa(MWR, 32'h000DF300, 1'b0, 8'h84);
		isa(MRD, 32'h000DF400, 1'b0, 8'h00);
		isa(MRD, 32'h000DF100, 1'b1, 8'h00);
		isa(IOR, 32'h000DF000, 1'b0, 8'h00);
		chk_word("reset count", 32'h00000102, {16'h0, rst_cnt});
		reg_wr(8'h90, 32'h000D0001);
		isa(MRD, 32'h000D0100, 1'b0, 8'h90);
		isa(MRD, 32'h000DF100, 1'b0, 8'h00);
		reg_wr(8'h90, 32'h000DF000);
		isa(MRD, 32'h000DF000, 1'b0, 8'h00);
		$display("test fieldbus done");
	endtask : t_fieldbus

	task automatic t_uart;
		isa(IOR, 32'h00000220, 1'b0, 8'h42);
		isa(IOW, 32'h1234022C, 1'b0, 8'h41);
		isa(IOR, 32'h00000230, 1'b0, 8'h00);
		isa(MRD, 32'h00000220, 1'b0, 8'h00);
		reg_wr(8'h9C, 32'h0800FFF0);
		isa(IOW, 32'h00000220, 1'b0, 8'h00);
		isa(IOR, 32'h00000220, 1'b0, 8'h42);
		reg_wr(8'h9C, 32'h0600FFF0);
		isa(IOR, 32'h00000220, 1'b1, 8'h00);
		isa(IOW, 32'h00000228, 1'b1, 8'h41);
		reg_wr(8'h98, 32'h00000220);
		isa(IOW, 32'h00000228, 1'b1, 8'h00);
		reg_wr(8'h9C, 32'h0C00FFF0);
		reg_wr(8'h98, 32'h00000221);
		isa(IOW, 32'h00000228, 1'b0, 8'h41);
		$display("test uart done");
	endtask : t_uart

	task automatic t_irq;
		logic [15:0] line [4] = '{16'h0400, 16'h0800, 16'h0080, 16'h0200};
		for (int i = 0; i < 4; i++) begin
			irq_req = 4'h1 << i;
			repeat (4) @(negedge clk_sys_i);
			chk_word("irq line", {16'h0, line[i]}, {16'h0, expansion_irq_o});
		end
		irq_req = 4'h0;
		soc_irq_i = 16'hFFFF;
		nmi_src_i = 1'b1;
		repeat (4) @(negedge clk_sys_i);
		chk_word("connector", 32'h0000DEF8, {16'h0, expansion_irq_o});
		chk_word("channel check", 32'h0, {31'h0, isa_chk_n_o});
		soc_irq_i = 16'h0000;
		nmi_src_i = 1'b0;
		$display("test irq done");
	endtask : t_irq

	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			conclude();
		end
	end

	initial begin
		{resetn_i, cfg_io_wr_i, cfg_io_rd_i, nmi_src_i, isa_wide_i} = 5'h0;
		{cfg_io_addr_i, soc_irq_i, cfg_io_wdata_i, isa_addr_i, irq_req} = '0;
		{isa_ior_n_i, isa_iow_n_i, isa_memr_n_i, isa_memw_n_i} = 4'hF;
		repeat (2) @(negedge clk_sys_i);
		resetn_i = 1'b1;
		t_regs();
		t_fieldbus();
		t_uart();
		t_irq();
		conclude();
	end
endmodule : isa_chip_select_decoder_test

bind icsd_top icsd_top_checker icsd_top_checker_inst (.*);

`default_nettype wire
